/* File: verilog/dsm_modulator.sv */
`timescale 1ns/1ns
module dsm_modulator #(
    parameter int N_CAPTURE = 4,
    parameter int N_CELL    = 4
) (
    input  wire logic                           clock,
    input  wire logic                           resetn,
    input  wire logic [dsm_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [7:0]                     reg_wdata,
    input  wire logic                           reg_write,
    input  wire logic                           reg_read,
    output logic      [7:0]                     reg_rdata,
    input  wire logic                           modulator_pin_route,
    input  wire logic                           low_carrier_pin_route,
    input  wire logic                           high_carrier_pin_route,
    input  wire logic                           system_clock_tap,
    input  wire logic                           internal_fast_oscillator,
    input  wire logic                           reference_clock_out,
    input  wire logic [N_CAPTURE-1:0]           capture_unit_out,
    input  wire logic                           capture_unit_five_out,
    input  wire logic [1:0]                     pulse_gen_out,
    input  wire logic                           numeric_oscillator_one,
    input  wire logic [1:0]                     comparator_out,
    input  wire logic [N_CELL-1:0]              logic_cell_out,
    input  wire logic [1:0]                     serial_port_tx,
    input  wire logic [1:0]                     sync_serial_port_sdo,
    output logic                                modulated_output
);
    logic [3:0]          wr_index;
    logic                idx_ok;
    logic [7:0]          wr_mask;
    logic [8*5-1:0]      regs_flat;
    logic [7:0]          r_ctrl;
    logic [7:0]          r_car;
    logic [7:0]          r_src;
    logic [7:0]          r_lsel;
    logic [7:0]          r_hsel;
    logic [7:0]          status_bits;
    logic                mod_raw;
    logic                car_h;
    logic                car_l;
    logic                car_h_ff;
    logic                nxt_car_h;
    logic                car_l_ff;
    logic                nxt_car_l;
    logic                out_ff;
    logic                nxt_out;
    logic                mixed;
    logic                high_fall;
    logic                low_fall;
    dsm_pkg::dsm_active_t act_ff;
    dsm_pkg::dsm_active_t nxt_act;

    function automatic logic [3:0] addr_index(input logic [dsm_pkg::ADDR_W-1:0] a);
        logic [3:0] idx;
        idx = 4'hf;
        case (a)
            dsm_pkg::OFS_CONTROL:  idx = 4'h0;
            dsm_pkg::OFS_CARRIER:  idx = 4'h1;
            dsm_pkg::OFS_SOURCE:   idx = 4'h2;
            dsm_pkg::OFS_LOW_SEL:  idx = 4'h3;
            dsm_pkg::OFS_HIGH_SEL: idx = 4'h4;
            default:               idx = 4'hf;
        endcase
        return idx;
    endfunction : addr_index

    function automatic logic carrier_pick(input logic [3:0] sel, input logic pin);
        logic c;
        c = 1'b0;
        case (sel)
            dsm_pkg::CAR_PIN:     c = pin;
            dsm_pkg::CAR_SYSCLK:  c = system_clock_tap;
            dsm_pkg::CAR_FASTOSC: c = internal_fast_oscillator;
            dsm_pkg::CAR_REFCLK:  c = reference_clock_out;
            dsm_pkg::CAR_OSC:     c = numeric_oscillator_one;
            dsm_pkg::CAR_CAP5:    c = capture_unit_five_out;
            default: begin
                if (sel >= dsm_pkg::CAR_CAPTURE && sel < dsm_pkg::CAR_PULSE) begin
                    c = capture_unit_out[2'(sel - dsm_pkg::CAR_CAPTURE)];
                end else if (sel >= dsm_pkg::CAR_PULSE && sel < dsm_pkg::CAR_OSC) begin
                    c = pulse_gen_out[1'(sel - dsm_pkg::CAR_PULSE)];
                end else if (sel >= dsm_pkg::CAR_CELL && sel < dsm_pkg::CAR_CAP5) begin
                    c = logic_cell_out[2'(sel - dsm_pkg::CAR_CELL)];
                end
            end
        endcase
        return c;
    endfunction : carrier_pick

    assign wr_index = addr_index(reg_addr);
    assign idx_ok   = (wr_index != 4'hf);

    always_comb begin
        case (wr_index)
            4'h0:    wr_mask = dsm_pkg::MASK_CONTROL;
            4'h1:    wr_mask = dsm_pkg::MASK_CARRIER;
            4'h2:    wr_mask = dsm_pkg::MASK_SOURCE;
            default: wr_mask = dsm_pkg::MASK_CARSEL;
        endcase
    end

    // software bit reads the stored value only, not the sampled stream
    assign status_bits = (wr_index == 4'h0) ? (8'(out_ff) << dsm_pkg::BIT_OUT) : 8'h00;

    dsm_reg_file #(
        .ADDR_W (dsm_pkg::ADDR_W),
        .NREG   (dsm_pkg::NUM_REGS)
    ) u_regs (
        .clock        (clock),
        .resetn       (resetn),
        .wr_en        (reg_write && idx_ok),
        .wr_index     (wr_index[2:0]),
        .wr_data      (reg_wdata),
        .wr_mask      (wr_mask),
        .rd_en        (reg_read),
        .rd_index     (wr_index[2:0]),
        .rd_valid_idx (idx_ok),
        .rd_status    (status_bits),
        .rd_data      (reg_rdata),
        .regs_flat    (regs_flat)
    );

    assign r_ctrl = regs_flat[7:0];
    assign r_car  = regs_flat[15:8];
    assign r_src  = regs_flat[23:16];
    assign r_lsel = regs_flat[31:24];
    assign r_hsel = regs_flat[39:32];

    // modulator source mux, reserved codes give low
    always_comb begin
        mod_raw = 1'b0;
        case (r_src[4:0])
            dsm_pkg::SRC_PIN:     mod_raw = modulator_pin_route;
            dsm_pkg::SRC_SWBIT:   mod_raw = r_ctrl[dsm_pkg::BIT_SWBIT];
            dsm_pkg::SRC_OSC:     mod_raw = numeric_oscillator_one;
            dsm_pkg::SRC_SER1_TX: mod_raw = serial_port_tx[0];
            dsm_pkg::SRC_SDO1:    mod_raw = sync_serial_port_sdo[0];
            dsm_pkg::SRC_SDO2:    mod_raw = sync_serial_port_sdo[1];
            dsm_pkg::SRC_CAP5:    mod_raw = capture_unit_five_out;
            dsm_pkg::SRC_SER2_TX: mod_raw = serial_port_tx[1];
            default: begin
                if (r_src[4:0] >= dsm_pkg::SRC_CAPTURE && r_src[4:0] < dsm_pkg::SRC_PULSE) begin
                    mod_raw = capture_unit_out[2'(r_src[4:0] - dsm_pkg::SRC_CAPTURE)];
                end else if (r_src[4:0] == dsm_pkg::SRC_PULSE ||
                             r_src[4:0] == dsm_pkg::SRC_PULSE + 5'h01) begin
                    mod_raw = pulse_gen_out[1'(r_src[4:0] - dsm_pkg::SRC_PULSE)];
                end else if (r_src[4:0] >= dsm_pkg::SRC_COMP &&
                             r_src[4:0] < dsm_pkg::SRC_CELL) begin
                    mod_raw = comparator_out[1'(r_src[4:0] - dsm_pkg::SRC_COMP)];
                end else if (r_src[4:0] >= dsm_pkg::SRC_CELL &&
                             r_src[4:0] < dsm_pkg::SRC_SER1_TX) begin
                    mod_raw = logic_cell_out[2'(r_src[4:0] - dsm_pkg::SRC_CELL)];
                end
            end
        endcase
    end

    // carrier polarity; shared encoding
    // always_comb so sources read inside the function also wake the mux
    always_comb begin
        car_h = carrier_pick(r_hsel[3:0], high_carrier_pin_route) ^ r_car[dsm_pkg::BIT_HPOL];
        car_l = carrier_pick(r_lsel[3:0], low_carrier_pin_route) ^ r_car[dsm_pkg::BIT_LPOL];
    end

    assign nxt_car_h = car_h;
    assign nxt_car_l = car_l;
    assign high_fall = car_h_ff && !car_h;
    assign low_fall  = car_l_ff && !car_l;

    always_comb begin
        nxt_act = act_ff;
        case (act_ff)
            dsm_pkg::ACT_LOW: begin
                if (mod_raw) begin
                    if (r_car[dsm_pkg::BIT_LSYNC] && car_l) begin
                        nxt_act = dsm_pkg::ACT_WAIT_HIGH;
                    end else begin
                        nxt_act = dsm_pkg::ACT_HIGH;
                    end
                end
            end
            dsm_pkg::ACT_WAIT_HIGH: begin
                if (!mod_raw) begin
                    nxt_act = dsm_pkg::ACT_LOW;
                end else if (low_fall || !car_l || !r_car[dsm_pkg::BIT_LSYNC]) begin
                    nxt_act = dsm_pkg::ACT_HIGH;
                end
            end
            dsm_pkg::ACT_HIGH: begin
                if (!mod_raw) begin
                    if (r_car[dsm_pkg::BIT_HSYNC] && car_h) begin
                        nxt_act = dsm_pkg::ACT_WAIT_LOW;
                    end else begin
                        nxt_act = dsm_pkg::ACT_LOW;
                    end
                end
            end
            dsm_pkg::ACT_WAIT_LOW: begin
                if (mod_raw) begin
                    nxt_act = dsm_pkg::ACT_HIGH;
                end else if (high_fall || !car_h || !r_car[dsm_pkg::BIT_HSYNC]) begin
                    nxt_act = dsm_pkg::ACT_LOW;
                end
            end
            default: nxt_act = dsm_pkg::ACT_LOW;
        endcase
    end

    // carrier AND modulator; no sync may give spurs
    always_comb begin
        case (act_ff)
            dsm_pkg::ACT_HIGH:      mixed = car_h && mod_raw;
            dsm_pkg::ACT_WAIT_LOW:  mixed = car_h;
            dsm_pkg::ACT_WAIT_HIGH: mixed = 1'b0;
            default:                mixed = car_l && mod_raw;
        endcase
        if (!r_ctrl[dsm_pkg::BIT_ENABLE]) begin
            nxt_out = 1'b0;
        end else begin
            nxt_out = mixed ^ r_ctrl[dsm_pkg::BIT_OUT_INV];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            act_ff   <= dsm_pkg::ACT_LOW;
            car_h_ff <= 1'b0;
            car_l_ff <= 1'b0;
            out_ff   <= 1'b0;
        end else begin
            act_ff   <= nxt_act;
            car_h_ff <= nxt_car_h;
            car_l_ff <= nxt_car_l;
            out_ff   <= nxt_out;
        end
    end

    assign modulated_output = out_ff;
endmodule : dsm_modulator

/* File: verilog/dsm_pkg.sv */
package dsm_pkg;
    // register offsets (byte addresses on the plain register port)
    localparam logic [11:0] OFS_CONTROL  = 12'h897;
    localparam logic [11:0] OFS_CARRIER  = 12'h898;
    localparam logic [11:0] OFS_SOURCE   = 12'h899;
    localparam logic [11:0] OFS_LOW_SEL  = 12'h89a;
    localparam logic [11:0] OFS_HIGH_SEL = 12'h89b;
    localparam int          ADDR_W       = 12;
    localparam int          NUM_REGS     = 5;
    // control register fields
    localparam int          BIT_ENABLE   = 7;
    localparam int          BIT_OUT      = 5;
    localparam int          BIT_OUT_INV  = 4;
    localparam int          BIT_SWBIT    = 0;
    // carrier polarity / sync fields
    localparam int          BIT_HPOL     = 5;
    localparam int          BIT_HSYNC    = 4;
    localparam int          BIT_LPOL     = 1;
    localparam int          BIT_LSYNC    = 0;
    // writable masks
    localparam logic [7:0]  MASK_CONTROL = 8'h91;
    localparam logic [7:0]  MASK_CARRIER = 8'h33;
    localparam logic [7:0]  MASK_SOURCE  = 8'h1f;
    localparam logic [7:0]  MASK_CARSEL  = 8'h0f;
    localparam logic [7:0]  RESET_VALUE  = 8'h00;
    // modulator source codes
    localparam logic [4:0]  SRC_PIN      = 5'h00;
    localparam logic [4:0]  SRC_SWBIT    = 5'h01;
    localparam logic [4:0]  SRC_CAPTURE  = 5'h02;
    localparam logic [4:0]  SRC_PULSE    = 5'h06;
    localparam logic [4:0]  SRC_OSC      = 5'h08;
    localparam logic [4:0]  SRC_COMP     = 5'h09;
    localparam logic [4:0]  SRC_CELL     = 5'h0b;
    localparam logic [4:0]  SRC_SER1_TX  = 5'h0f;
    localparam logic [4:0]  SRC_SDO1     = 5'h10;
    localparam logic [4:0]  SRC_SDO2     = 5'h11;
    localparam logic [4:0]  SRC_CAP5     = 5'h12;
    localparam logic [4:0]  SRC_SER2_TX  = 5'h13;
    // carrier source codes
    localparam logic [3:0]  CAR_PIN      = 4'h0;
    localparam logic [3:0]  CAR_SYSCLK   = 4'h1;
    localparam logic [3:0]  CAR_FASTOSC  = 4'h2;
    localparam logic [3:0]  CAR_REFCLK   = 4'h3;
    localparam logic [3:0]  CAR_CAPTURE  = 4'h4;
    localparam logic [3:0]  CAR_PULSE    = 4'h8;
    localparam logic [3:0]  CAR_OSC      = 4'ha;
    localparam logic [3:0]  CAR_CELL     = 4'hb;
    localparam logic [3:0]  CAR_CAP5     = 4'hf;

    typedef enum logic [1:0] {
        ACT_LOW       = 2'b00,
        ACT_WAIT_HIGH = 2'b01,
        ACT_HIGH      = 2'b11,
        ACT_WAIT_LOW  = 2'b10
    } dsm_active_t;
endpackage : dsm_pkg

/* File: verilog/dsm_reg_file.sv */
`timescale 1ns/1ns
module dsm_reg_file #(
    parameter int ADDR_W = 12,
    parameter int NREG   = 5
) (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              wr_en,
    input  wire logic [2:0]        wr_index,
    input  wire logic [7:0]        wr_data,
    input  wire logic [7:0]        wr_mask,
    input  wire logic              rd_en,
    input  wire logic [2:0]        rd_index,
    input  wire logic              rd_valid_idx,
    input  wire logic [7:0]        rd_status,
    output logic      [7:0]        rd_data,
    output logic      [8*NREG-1:0] regs_flat
);
    logic [7:0] mem_ff [NREG];
    logic [7:0] nxt_mem [NREG];
    logic [7:0] rd_data_ff;
    logic [7:0] nxt_rd_data;

    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            nxt_mem[i] = mem_ff[i];
        end
        if (wr_en && (int'(wr_index) < NREG)) begin
            nxt_mem[wr_index] = wr_data & wr_mask;
        end
        nxt_rd_data = 8'h00;
        // read data answer one cycle after the strobe, unmapped reads zero
        if (rd_en && rd_valid_idx && (int'(rd_index) < NREG)) begin
            nxt_rd_data = mem_ff[rd_index] | rd_status;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NREG; i++) begin
                mem_ff[i] <= dsm_pkg::RESET_VALUE;
            end
            rd_data_ff <= 8'h00;
        end else begin
            for (int i = 0; i < NREG; i++) begin
                mem_ff[i] <= nxt_mem[i];
            end
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;
    for (genvar g = 0; g < NREG; g++) begin : g_flat
        assign regs_flat[8*g +: 8] = mem_ff[g];
    end
endmodule : dsm_reg_file

/* File: testbench/dsm_checker.sv */
`timescale 1ns/1ns
module dsm_checker (
    input  wire logic [dsm_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                       clock,
    input  wire logic                       resetn,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_write,
    input  wire logic                       reg_read,
    input  wire logic [7:0]                 reg_rdata,
    input  wire logic                       high_carrier_pin_route,
    input  wire logic                       modulated_output
);
    logic [39:0] m_ff;
    logic [39:0] nxt_m;
    logic [11:0] ofs;
    logic [7:0]  ctl;
    logic [7:0]  car;
    logic [7:0]  src;
    logic [7:0]  hs;
    // shadow copy of the register file, raw; masks applied at use
    assign ofs = reg_addr - dsm_pkg::OFS_CONTROL;
    assign ctl = m_ff[7:0] & dsm_pkg::MASK_CONTROL;
    assign car = m_ff[15:8] & dsm_pkg::MASK_CARRIER;
    assign src = m_ff[23:16] & dsm_pkg::MASK_SOURCE;
    assign hs  = m_ff[39:32] & dsm_pkg::MASK_CARSEL;
    always_comb begin
        nxt_m = m_ff;
        if (reg_write && ofs < 12'h005) begin
            nxt_m[ofs*8 +: 8] = reg_wdata;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            m_ff <= '0;
        end else begin
            m_ff <= nxt_m;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (reg_read && ofs > 12'h004 |=> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    a_status_read: assert property (reg_read && ofs == 12'h000
        |=> reg_rdata[5] == $past(modulated_output)) else $error("status bit differs from output");
    a_ctl_readback: assert property (reg_read && ofs == 12'h000
        |=> (reg_rdata & 8'hdf) == $past(ctl)) else $error("control readback wrong");
    a_src_readback: assert property ((reg_write && ofs == 12'h002) ##1
        (reg_read && ofs == 12'h002) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1f))
        else $error("source select readback wrong");
    a_disabled_low: assert property (!ctl[7] |=> !modulated_output)
        else $error("output not low while disabled");
    a_idle_level: assert property ((ctl[7] && src == 8'h01 && !ctl[0] && !car[4])[*3]
        |=> modulated_output == $past(ctl[4])) else $error("idle level wrong");
    a_high_gate: assert property ((ctl[7] && ctl[0] && !ctl[4] && src == 8'h01
        && car == 8'h00 && hs == 8'h00)[*3] |=> modulated_output == $past(high_carrier_pin_route))
        else $error("output does not follow high carrier");
endmodule : dsm_checker

/* File: testbench/dsm_src_model.sv */
`timescale 1ns/1ns
module dsm_src_model (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [23:0] levels,
    input  wire logic [23:0] toggle,
    output logic      [23:0] src_bus
);
    logic [1:0]  ph_ff;
    logic [1:0]  nxt_ph;
    logic [23:0] nxt_bus;
    // sources move only on clock edges, like on-chip peripheral outputs
    always_comb begin
        nxt_ph  = ph_ff + 2'h1;
        nxt_bus = levels ^ (toggle & {24{ph_ff[1]}});
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ph_ff   <= 2'h0;
            src_bus <= 24'h000000;
        end else begin
            ph_ff   <= nxt_ph;
            src_bus <= nxt_bus;
        end
    end
endmodule : dsm_src_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    typedef struct packed {
        logic [4:0]  src;
        logic [3:0]  hsel;
        logic [7:0]  pol;
        logic [7:0]  ctl;
        logic [23:0] lv;
        logic        exp;
    } dsm_row_t;
    logic        clock, resetn, reg_write, reg_read, modulated_output;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [23:0] levels, toggle, src_bus;
    logic [23:0] lb;
    int          n_fail, num_checks, ones, ix;
    dsm_row_t    rows[$];
    dsm_row_t    r;
    localparam logic [7:0] MSK [4] = '{8'h33, 8'h1f, 8'h0f, 8'h0f};
    dsm_src_model dsm_src_model_i (.clock(clock), .resetn(resetn), .levels(levels),
        .toggle(toggle), .src_bus(src_bus));
    dsm_modulator dsm_modulator_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .modulator_pin_route(src_bus[0]), .low_carrier_pin_route(src_bus[1]),
        .high_carrier_pin_route(src_bus[2]), .system_clock_tap(src_bus[3]),
        .internal_fast_oscillator(src_bus[4]), .reference_clock_out(src_bus[5]),
        .capture_unit_out(src_bus[9:6]), .capture_unit_five_out(src_bus[10]),
        .pulse_gen_out(src_bus[12:11]), .numeric_oscillator_one(src_bus[13]),
        .comparator_out(src_bus[15:14]), .logic_cell_out(src_bus[19:16]),
        .serial_port_tx(src_bus[21:20]), .sync_serial_port_sdo(src_bus[23:22]),
        .modulated_output(modulated_output));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // long enough for every test with a wide margin
    initial begin
        #(40 * 6000);
        n_fail++;
        results();
    end
    function automatic int src_idx(input int c);
        case (c)
            0: return 0;
            1: return -2;
            2, 3, 4, 5: return c + 4;
            6, 7: return c + 5;
            8, 9, 10, 11, 12, 13, 14: return c + 5;
            15: return 20;
            16, 17: return c + 6;
            18: return 10;
            19: return 21;
            default: return -1;
        endcase
    endfunction : src_idx
    function automatic int car_idx(input int k);
        if (k == 0) return 2;
        if (k < 8) return k + 2;
        if (k < 11) return k + 3;
        if (k < 15) return k + 5;
        return 10;
    endfunction : car_idx
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clock);
            reg_write <= 1'b0;
            reg_read  <= 1'b0;
        end
    endtask : cyc
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_read  <= 1'b0;
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask : wr
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read  <= 1'b1;
        reg_addr  <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, exp);
    endtask : rd
    task automatic chk_out(input logic e);
        @(negedge clock);
        chk({7'h00, modulated_output}, {7'h00, e});
    endtask : chk_out
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        {resetn, reg_write, reg_read, reg_addr, reg_wdata, levels, toggle} = '0;
        for (int c = 0; c < 32; c++) begin
            ix = src_idx(c);
            r = '{c[4:0], 4'h0, 8'h00, (c == 1) ? 8'h81 : 8'h80, 24'h4, ix != -1};
            if (ix >= 0) r.lv[ix] = 1'b1;
            rows.push_back(r);
        end
        for (int k = 0; k < 16; k++) begin
            for (int j = 0; j < 2; j++) begin
                rows.push_back('{5'h01, k[3:0], j ? 8'h20 : 8'h00, 8'h81, 24'h1 << car_idx(k), !j});
            end
        end
        rows.push_back('{5'h01, 4'h0, 8'h00, 8'h90, 24'h0, 1'b1});
        rows.push_back('{5'h01, 4'h0, 8'h00, 8'h91, 24'h4, 1'b0});
        rows.push_back('{5'h01, 4'h0, 8'h00, 8'h81, 24'h0, 1'b0});
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(12'(dsm_pkg::OFS_CONTROL + i), 8'h00);
        rd(12'h896, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(12'(dsm_pkg::OFS_CARRIER + i), 8'hff);
            rd(12'(dsm_pkg::OFS_CARRIER + i), MSK[i]);
        end
        wr(12'h89c, 8'hff);
        rd(12'h89c, 8'h00);
        $display("test registers done");
        foreach (rows[i]) begin
            wr(dsm_pkg::OFS_SOURCE, {3'h0, rows[i].src});
            wr(dsm_pkg::OFS_HIGH_SEL, {4'h0, rows[i].hsel});
            wr(dsm_pkg::OFS_CARRIER, rows[i].pol);
            wr(dsm_pkg::OFS_CONTROL, rows[i].ctl);
            levels <= rows[i].lv;
            cyc(5);
            chk_out(rows[i].exp);
            rd(dsm_pkg::OFS_CONTROL, (rows[i].ctl & 8'h91) | {2'h0, rows[i].exp, 5'h00});
        end
        $display("test table done");
        for (int s = 1; s >= 0; s--) begin
            wr(dsm_pkg::OFS_CARRIER, s ? 8'h10 : 8'h00);
            wr(dsm_pkg::OFS_HIGH_SEL, 8'h00);
            levels <= 24'h4;
            wr(dsm_pkg::OFS_CONTROL, 8'h81);
            cyc(5);
            wr(dsm_pkg::OFS_CONTROL, 8'h80);
            cyc(5);
            chk_out(s);
            @(posedge clock);
            levels <= 24'h0;
            cyc(4);
            chk_out(1'b0);
        end
        // every low carrier code, odd codes inverted; a wrong pick skips the wait on even codes and holds it on odd codes
        for (int k = 0; k < 16; k++) begin
            lb = 24'h1 << ((k == 0) ? 1 : car_idx(k));
            wr(dsm_pkg::OFS_CARRIER, {6'h00, k[0], 1'b1});
            wr(dsm_pkg::OFS_LOW_SEL, {4'h0, k[3:0]});
            levels <= k[0] ? 24'h4 : (24'h4 | lb);
            wr(dsm_pkg::OFS_CONTROL, 8'h80);
            cyc(5);
            wr(dsm_pkg::OFS_CONTROL, 8'h81);
            cyc(5);
            chk_out(1'b0);
            @(posedge clock);
            levels <= k[0] ? (24'h4 | lb) : 24'h4;
            cyc(4);
            chk_out(1'b1);
        end
        $display("test sync done");
        wr(dsm_pkg::OFS_CARRIER, 8'h00);
        levels <= 24'h0;
        toggle <= 24'h4;
        cyc(4);
        ones = 0;
        repeat (16) begin
            @(negedge clock);
            ones += int'(modulated_output === 1'b1);
        end
        chk(ones[7:0], 8'h08);
        wr(dsm_pkg::OFS_CONTROL, 8'h11);
        toggle <= 24'h0;
        cyc(3);
        chk_out(1'b0);
        rd(dsm_pkg::OFS_SOURCE, 8'h01);
        wr(dsm_pkg::OFS_CONTROL, 8'h90);
        cyc(4);
        chk_out(1'b1);
        @(posedge clock);
        resetn <= 1'b0;
        chk_out(1'b0);
        cyc(3);
        resetn <= 1'b1;
        rd(dsm_pkg::OFS_CONTROL, 8'h00);
        rd(dsm_pkg::OFS_SOURCE, 8'h00);
        $display("test enable and reset done");
        results();
    end
endmodule : tb_top
bind dsm_modulator dsm_checker dsm_checker_i (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .high_carrier_pin_route(high_carrier_pin_route),
    .modulated_output(modulated_output));
